// file: hdl/uoscrt_consts.svh
// Notes on behaviour
// R1: A clear line polarity bit swaps the data-plus and data-minus signals, a set bit keeps them as named.
// R2: The bias resistor off bit at position 3 keeps the oscillator bias resistor on when clear and turns it off when set.
// R3: A set oscillator off bit at position 2 stops the oscillator, floats its output pin and holds its core clock low.
// R4: Access width code 1h allows high byte accesses, 2h low byte accesses, and 3h is reserved.
// R5: Access width code 0 allows full word accesses to the USB module.
// R6: The RTC domain has no dynamic clock gating and its clock runs whenever its oscillator runs.
// R7: With the RTC oscillator disabled the RTC registers from I/O address 1900h cannot be reached, though the RTC stays powered.
// R8: The RTC power register at 1930h controls regulator power down, the wake pin and the RTC clock output pin.
// R9: After clearing the oscillator off bit, software waits for the oscillator to settle before ungating the USB peripheral clock.
`ifndef UOSCRT_CONSTS_SVH
`define UOSCRT_CONSTS_SVH
`define UOSCRT_USB_SCR_ADDR   16'h1C32
`define UOSCRT_RTC_BASE_ADDR  16'h1900
`define UOSCRT_RTC_LAST_ADDR  16'h19FF
`define UOSCRT_RTC_PMGT_ADDR  16'h1930
`define UOSCRT_SCR_RESET      16'hA04C
`define UOSCRT_SCR_WMASK      16'hF04F
`define UOSCRT_PMGT_RESET     16'h0010
`define UOSCRT_PMGT_WMASK     16'h001F
`define UOSCRT_POL_BIT        6
`define UOSCRT_BIAS_BIT       3
`define UOSCRT_OSC_BIT        2
`define UOSCRT_BM_LSB         0
`define UOSCRT_WAKE_BIT       4
`define UOSCRT_CLKOUT_BIT     3
`define UOSCRT_LDO_LSB        0
`endif

// file: hdl/uoscrt_pkg.sv
package uoscrt_pkg;
  typedef enum logic [1:0] {
    UOSCRT_WORD,
    UOSCRT_HIGH_BYTE,
    UOSCRT_LOW_BYTE,
    UOSCRT_RSVD
  } uoscrt_width_e;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } uoscrt_req_s;
  typedef struct packed {
    logic        usb_pwdn;
    logic        sess_end_en;
    logic        vbus_det_en;
    logic        pll_force;
    logic        usb_line_polarity_select;
    logic        usb_osc_bias_resistor_off;
    logic        usb_osc_off;
    uoscrt_width_e cpu_access_width_select;
  } uoscrt_usb_ctrl_s;
endpackage

// file: hdl/uoscrt_reg.sv
`timescale 1ns/1ps
`include "uoscrt_consts.svh"
module uoscrt_reg #(
  parameter logic [15:0] RESET_VAL = 16'h0000,
  parameter logic [15:0] WMASK     = 16'hFFFF
) (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  // Write port
  input  wire logic        we_i,
  input  wire logic [15:0] wdata_i,
  // Stored value
  output logic      [15:0] q_o
);
  logic [15:0] q_r;
  logic [15:0] q_nxt;
  // Only writable bits take new data; reserved bits keep reset value
  assign q_nxt = we_i ? ((wdata_i & WMASK) | (RESET_VAL & ~WMASK)) : q_r;
  // Storage
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) q_r <= RESET_VAL;
    else q_r <= q_nxt;
  end
  assign q_o = q_r;
endmodule // uoscrt_reg

// file: hdl/uoscrt_top.sv
`timescale 1ns/1ps
`include "uoscrt_consts.svh"
module uoscrt_top (
  // Clock and reset
  input  wire logic                     clk_sys_i,
  input  wire logic                     resetn_i,
  // I/O register access
  input  wire uoscrt_pkg::uoscrt_req_s  io_req_i,
  output logic                          io_ack_o,
  output logic [15:0]                   io_rdata_o,
  // RTC oscillator strap, high when the crystal is fitted
  input  wire logic                     rtc_osc_present_i,
  input  wire logic                     rtc_osc_clk_i,
  output logic                          rtc_clk_o,
  // USB data lines from the core and to the pins
  input  wire logic                     core_dp_i,
  input  wire logic                     core_dm_i,
  output logic                          pin_dp_o,
  output logic                          pin_dm_o,
  // USB oscillator
  input  wire logic                     usb_osc_input_pin_i,
  output logic                          usb_osc_output_pin_o,
  output logic                          usb_osc_output_pin_oe_o,
  output logic                          usb_osc_run_o,
  output logic                          usb_osc_bias_en_o,
  output logic                          usb_osc_core_clk_o,
  // USB module control and access width
  output uoscrt_pkg::uoscrt_usb_ctrl_s  usb_ctrl_o,
  output logic                          usb_word_access_o,
  output logic                          usb_high_byte_o,
  output logic                          usb_low_byte_o,
  // RTC power control pins
  output logic [2:0]                    ldo_pwrdn_o,
  output logic                          wake_pin_o,
  output logic                          wake_pin_oe_o,
  output logic                          rtc_clock_out_pin_o
);
  import uoscrt_pkg::*;

  logic [15:0] usb_sys_ctrl_reg;
  logic [15:0] rtc_power_ctrl_reg;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic        ack_r;
  logic        rtc_osc_present_r;
  logic        strap_taken_r;
  logic        cpol_r;
  logic [1:0]  width_code;
  logic        hit_scr;
  logic        hit_rtc_range;
  logic        hit_pmgt;
  logic        rtc_ok;
  logic        osc_off;

  // Strap is caught once after reset release
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      strap_taken_r     <= 1'b0;
      rtc_osc_present_r <= 1'b0;
    end else if (!strap_taken_r) begin
      strap_taken_r     <= 1'b1;
      rtc_osc_present_r <= rtc_osc_present_i;
    end
  end

  // Address decode
  assign hit_scr       = io_req_i.addr == `UOSCRT_USB_SCR_ADDR;
  assign hit_rtc_range = io_req_i.addr >= `UOSCRT_RTC_BASE_ADDR &&
                         io_req_i.addr <= `UOSCRT_RTC_LAST_ADDR;
  assign rtc_ok        = rtc_osc_present_r; // R7
  assign hit_pmgt      = io_req_i.addr == `UOSCRT_RTC_PMGT_ADDR && rtc_ok; // R7

  // USB system control register
  uoscrt_reg #(
    .RESET_VAL (`UOSCRT_SCR_RESET),
    .WMASK     (`UOSCRT_SCR_WMASK)
  ) u_scr (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .we_i      (io_req_i.wr && hit_scr),
    .wdata_i   (io_req_i.wdata),
    .q_o       (usb_sys_ctrl_reg)
  );

  // RTC power control register, blocked without the RTC oscillator
  uoscrt_reg #(
    .RESET_VAL (`UOSCRT_PMGT_RESET),
    .WMASK     (`UOSCRT_PMGT_WMASK)
  ) u_pmgt (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .we_i      (io_req_i.wr && hit_pmgt), // R7
    .wdata_i   (io_req_i.wdata),
    .q_o       (rtc_power_ctrl_reg)
  );

  // Read mux; unreachable RTC space reads zero
  assign rdata_nxt = hit_scr  ? usb_sys_ctrl_reg :
                     hit_pmgt ? rtc_power_ctrl_reg : 16'h0000; // R7

  // Read data and acknowledge
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      rdata_r <= 16'h0000;
      ack_r   <= 1'b0;
    end else begin
      ack_r <= (io_req_i.rd || io_req_i.wr) &&
               (hit_scr || hit_pmgt || !hit_rtc_range);
      if (io_req_i.rd) rdata_r <= rdata_nxt;
    end
  end
  assign io_ack_o   = ack_r;
  assign io_rdata_o = rdata_r;

  // Control fields
  assign usb_ctrl_o.usb_pwdn    = usb_sys_ctrl_reg[15];
  assign usb_ctrl_o.sess_end_en = usb_sys_ctrl_reg[14];
  assign usb_ctrl_o.vbus_det_en = usb_sys_ctrl_reg[13];
  assign usb_ctrl_o.pll_force   = usb_sys_ctrl_reg[12];
  assign usb_ctrl_o.usb_line_polarity_select =
    usb_sys_ctrl_reg[`UOSCRT_POL_BIT];
  assign usb_ctrl_o.usb_osc_bias_resistor_off =
    usb_sys_ctrl_reg[`UOSCRT_BIAS_BIT];
  assign usb_ctrl_o.usb_osc_off = usb_sys_ctrl_reg[`UOSCRT_OSC_BIT];
  assign width_code = usb_sys_ctrl_reg[`UOSCRT_BM_LSB +: 2];
  assign usb_ctrl_o.cpu_access_width_select = uoscrt_width_e'(width_code);

  // Data line polarity
  assign pin_dp_o = usb_sys_ctrl_reg[`UOSCRT_POL_BIT] ? core_dp_i
                                                      : core_dm_i; // R1
  assign pin_dm_o = usb_sys_ctrl_reg[`UOSCRT_POL_BIT] ? core_dm_i
                                                      : core_dp_i; // R1

  // Oscillator bias and enable
  assign usb_osc_bias_en_o = !usb_sys_ctrl_reg[`UOSCRT_BIAS_BIT]; // R2
  assign osc_off           = usb_sys_ctrl_reg[`UOSCRT_OSC_BIT];
  assign usb_osc_run_o     = !osc_off; // R3
  assign usb_osc_output_pin_oe_o = !osc_off; // R3
  assign usb_osc_output_pin_o    = !osc_off && !usb_osc_input_pin_i;

  // Core clock held low while stopped (restart enable registered on clk_sys_i)
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) cpol_r <= 1'b0;
    else cpol_r <= !osc_off;
  end
  assign usb_osc_core_clk_o = cpol_r && !osc_off && usb_osc_input_pin_i; // R3

  // Access width decode
  assign usb_word_access_o = width_code == UOSCRT_WORD;      // R5
  assign usb_high_byte_o   = width_code == UOSCRT_HIGH_BYTE; // R4
  assign usb_low_byte_o    = width_code == UOSCRT_LOW_BYTE;  // R4

  // RTC clock passes ungated whenever its oscillator runs
  assign rtc_clk_o = rtc_osc_clk_i; // R6

  // RTC power control outputs
  assign ldo_pwrdn_o   = rtc_power_ctrl_reg[`UOSCRT_LDO_LSB +: 3]; // R8
  assign rtc_clock_out_pin_o = rtc_power_ctrl_reg[`UOSCRT_CLKOUT_BIT]; // R8
  assign wake_pin_o    = 1'b0;
  assign wake_pin_oe_o = !rtc_power_ctrl_reg[`UOSCRT_WAKE_BIT]; // R8
endmodule // uoscrt_top

// file: testbench/uoscrt_props.sv
`timescale 1ns/1ps
module uoscrt_chk (
  // Clock, reset and access
  input wire logic                         clk_sys_i,
  input wire logic                         resetn_i,
  input wire uoscrt_pkg::uoscrt_req_s      io_req_i,
  input wire logic                         io_ack_o,
  input wire logic                         rtc_osc_present_i,
  // Pins and controls
  input wire logic                         rtc_osc_clk_i,
  input wire logic                         rtc_clk_o,
  input wire logic                         core_dp_i,
  input wire logic                         core_dm_i,
  input wire logic                         pin_dp_o,
  input wire logic                         usb_osc_output_pin_oe_o,
  input wire logic                         usb_osc_bias_en_o,
  input wire logic                         usb_osc_core_clk_o,
  input wire uoscrt_pkg::uoscrt_usb_ctrl_s usb_ctrl_o,
  input wire logic                         usb_word_access_o,
  input wire logic                         usb_high_byte_o,
  input wire logic                         usb_low_byte_o,
  input wire logic [2:0]                   ldo_pwrdn_o,
  input wire logic                         wake_pin_oe_o
);
  import uoscrt_pkg::*;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  // Decodes of the request
  wire scr_wr = io_req_i.wr && io_req_i.addr == 16'h1C32;
  wire rtc_go = (io_req_i.wr || io_req_i.rd) && io_req_i.addr[15:8] == 8'h19;
  wire pm_wr  = io_req_i.wr && io_req_i.addr == 16'h1930 && rtc_osc_present_i;
  property p_pol; pin_dp_o ==
    (usb_ctrl_o.usb_line_polarity_select ? core_dp_i : core_dm_i); endproperty
  a_pol: assert property (p_pol) else $error("polarity wrong");
  property p_bias;
    scr_wr |=> usb_osc_bias_en_o != $past(io_req_i.wdata[3]); endproperty
  a_bias: assert property (p_bias) else $error("bias wrong");
  property p_off; usb_ctrl_o.usb_osc_off |->
    !usb_osc_output_pin_oe_o && !usb_osc_core_clk_o; endproperty
  a_off: assert property (p_off) else $error("osc not off");
  property p_byte; {usb_high_byte_o, usb_low_byte_o} == {usb_ctrl_o.
    cpu_access_width_select == UOSCRT_HIGH_BYTE, usb_ctrl_o.
    cpu_access_width_select == UOSCRT_LOW_BYTE}; endproperty
  a_byte: assert property (p_byte) else $error("byte select wrong");
  property p_word; scr_wr && io_req_i.wdata[1:0] == 2'h0 |=>
    usb_word_access_o; endproperty
  a_word: assert property (p_word) else $error("word access off");
  property p_rclk; rtc_clk_o == rtc_osc_clk_i; endproperty
  a_rclk: assert property (p_rclk) else $error("rtc clock gated");
  property p_rtc; rtc_go && !rtc_osc_present_i |=> !io_ack_o; endproperty
  a_rtc: assert property (p_rtc) else $error("rtc acked");
  property p_pm; pm_wr |=> ldo_pwrdn_o == $past(io_req_i.wdata[2:0]) &&
    wake_pin_oe_o != $past(io_req_i.wdata[4]); endproperty
  a_pm: assert property (p_pm) else $error("power control wrong");
endmodule // uoscrt_chk
bind uoscrt_top uoscrt_chk u_chk (.clk_sys_i, .resetn_i, .io_req_i,
  .io_ack_o, .rtc_osc_present_i, .rtc_osc_clk_i, .rtc_clk_o, .core_dp_i,
  .core_dm_i, .pin_dp_o, .usb_osc_output_pin_oe_o, .usb_osc_bias_en_o,
  .usb_osc_core_clk_o, .usb_ctrl_o, .usb_word_access_o, .usb_high_byte_o,
  .usb_low_byte_o, .ldo_pwrdn_o, .wake_pin_oe_o);

// file: testbench/usb_osc_and_rtc_domain_control_bench.sv
`timescale 1ns/1ps
module usb_osc_and_rtc_domain_control_bench;
  import uoscrt_pkg::*;
  logic clk_sys_i, resetn_i, rtc_osc_present_i, rtc_osc_clk_i, io_ack_o;
  logic core_dp_i, core_dm_i, pin_dp_o, pin_dm_o, usb_osc_input_pin_i;
  logic usb_osc_output_pin_o, usb_osc_output_pin_oe_o, usb_osc_run_o;
  logic usb_osc_bias_en_o, usb_osc_core_clk_o, rtc_clk_o, wake_pin_o;
  logic usb_word_access_o, usb_high_byte_o, usb_low_byte_o, wake_pin_oe_o;
  logic rtc_clock_out_pin_o;
  logic [15:0] io_rdata_o;
  logic [2:0] ldo_pwrdn_o;
  uoscrt_req_s io_req_i;
  uoscrt_usb_ctrl_s usb_ctrl_o;
  int n_errors = 0, n_tests = 0, cyc = 0;
  uoscrt_top u_dut (.clk_sys_i, .resetn_i, .io_req_i, .io_ack_o, .io_rdata_o,
    .rtc_osc_present_i, .rtc_osc_clk_i, .rtc_clk_o, .core_dp_i, .core_dm_i,
    .pin_dp_o, .pin_dm_o, .usb_osc_input_pin_i, .usb_osc_output_pin_o,
    .usb_osc_output_pin_oe_o, .usb_osc_run_o, .usb_osc_bias_en_o,
    .usb_osc_core_clk_o, .usb_ctrl_o, .usb_word_access_o, .usb_high_byte_o,
    .usb_low_byte_o, .ldo_pwrdn_o, .wake_pin_o, .wake_pin_oe_o,
    .rtc_clock_out_pin_o);
  // Clock and hang guard
  initial begin
    clk_sys_i = 0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      n_errors++;
      finish_test();
    end
  end
  // Compare one result
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One access held for one edge, answer seen the cycle after
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d,
                     input logic k, input logic [15:0] r);
    @(posedge clk_sys_i);
    io_req_i <= '{w, !w, a, d};
    @(posedge clk_sys_i);
    io_req_i <= '0;
    #1;
    chk(16'(io_ack_o), 16'(k));
    if (k && !w) chk(io_rdata_o, r);
  endtask
  // Reset with the strap set during reset
  task automatic rst(input logic s);
    @(posedge clk_sys_i);
    resetn_i <= 0;
    rtc_osc_present_i <= s;
    repeat (10) @(posedge clk_sys_i);
    resetn_i <= 1;
    @(posedge clk_sys_i);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence
  initial begin
    {resetn_i, rtc_osc_present_i, rtc_osc_clk_i, core_dm_i} = '0;
    {core_dp_i, usb_osc_input_pin_i} = 2'h3;
    io_req_i = '0;
    rst(1);
    acc(0, 16'h1C32, 16'h0000, 1, 16'hA04C);
    acc(0, 16'h1930, 16'h0000, 1, 16'h0010);
    chk(16'({usb_osc_output_pin_oe_o, usb_osc_core_clk_o}), 16'h0);
    chk(16'(usb_osc_bias_en_o), 16'h0);
    chk(16'({usb_osc_run_o, usb_osc_output_pin_o, wake_pin_o}), 16'h0);
    chk(16'(usb_ctrl_o), 16'h015C);
    acc(1, 16'h1C32, 16'hFFFF, 1, 16'h0);
    acc(0, 16'h1C32, 16'h0000, 1, 16'hF04F);
    chk(16'({usb_word_access_o, usb_high_byte_o, usb_low_byte_o}), 0);
    for (int c = 0; c < 3; c++) begin
      acc(1, 16'h1C32, 16'(c), 1, 16'h0);
      chk(16'({usb_word_access_o, usb_high_byte_o, usb_low_byte_o}),
          16'(4 >> c));
    end
    // Oscillator was switched on above; let it settle before relying on it
    repeat (4) @(negedge clk_sys_i);
    @(posedge clk_sys_i) usb_osc_input_pin_i <= 0;
    @(negedge clk_sys_i);
    chk(16'({usb_osc_run_o, usb_osc_output_pin_o, usb_osc_core_clk_o}),
        16'h6);
    @(posedge clk_sys_i) usb_osc_input_pin_i <= 1;
    @(negedge clk_sys_i);
    chk(16'({pin_dp_o, pin_dm_o, usb_osc_output_pin_oe_o,
             usb_osc_core_clk_o, usb_osc_bias_en_o}), 16'h0F);
    @(posedge clk_sys_i) rtc_osc_clk_i <= 1;
    acc(1, 16'h1C32, 16'h0040, 1, 16'h0);
    chk(16'({pin_dp_o, pin_dm_o, rtc_clk_o}), 16'h5);
    acc(1, 16'h1930, 16'hFFFF, 1, 16'h0);
    acc(0, 16'h1930, 16'h0000, 1, 16'h001F);
    chk(16'({ldo_pwrdn_o, rtc_clock_out_pin_o, wake_pin_oe_o}), 16'h1E);
    acc(1, 16'h1930, 16'h0005, 1, 16'h0);
    chk(16'({ldo_pwrdn_o, rtc_clock_out_pin_o, wake_pin_oe_o}), 16'h15);
    acc(0, 16'h0000, 16'h0000, 1, 16'h0);
    acc(0, 16'h1900, 16'h0000, 0, 16'h0);
    rst(0);
    acc(1, 16'h1930, 16'hFFFF, 0, 16'h0);
    chk(16'({ldo_pwrdn_o, rtc_clock_out_pin_o, wake_pin_oe_o}), 16'h0);
    acc(0, 16'h1930, 16'h0000, 0, 16'h0);
    acc(0, 16'h1C32, 16'h0000, 1, 16'hA04C);
    finish_test();
  end
endmodule // usb_osc_and_rtc_domain_control_bench
